// >>> pscc_pkg.sv
// constants and types for the pcm stream command controller
// Summary of operation
// - from params-set, only set-parameters or prepare are accepted next
// - prepared holds resources; accepts set-parameters, prepare, start or release
// - start puts stream running and unmuted; only stop may follow
// - stop mutes and halts stream; only start or release may follow
// - release frees resources; only set-parameters or prepare may follow
// - config response: header, association, features, flags, direction, channels, formats, rates, chmap
// - feature bits from 0: host shmem, guest shmem, polling, periods, xruns
// - rate bits indexed 0 for 5512 Hz up to 384000 Hz ascending
// - flags bit 0 means channel map; first max-channels entries valid
// - without channel-map flag every chmap entry is position code 0
// - never report undefined direction, feature, format or rate bits
// - only interleaved sample layout is supported
// - association is fixed; lower value means higher priority
// - polling suppresses tx/rx notifications; event features enable period/xrun events
// - intermediate buffer at least the requested buffer size
// - request codes 0x0100 upward: query, set, prepare, release, start, stop
// - status codes 0x8000 ok, then malformed, not supported, io error
package pscc_pkg;
    localparam logic [31:0] CODE_GET_CONFIG = 32'h0000_0100;
    localparam logic [31:0] CODE_SET_PARAMS = 32'h0000_0101;
    localparam logic [31:0] CODE_PREPARE    = 32'h0000_0102;
    localparam logic [31:0] CODE_RELEASE    = 32'h0000_0103;
    localparam logic [31:0] CODE_START      = 32'h0000_0104;
    localparam logic [31:0] CODE_STOP       = 32'h0000_0105;
    localparam logic [31:0] ST_OK           = 32'h0000_8000;
    localparam logic [31:0] ST_BAD_MSG      = 32'h0000_8001;
    localparam logic [31:0] ST_NOT_SUPP     = 32'h0000_8002;
    localparam logic [31:0] ST_IO_ERR       = 32'h0000_8003;
    localparam int          FEAT_SHMEM_HOST  = 0;
    localparam int          FEAT_SHMEM_GUEST = 1;
    localparam int          FEAT_POLLING     = 2;
    localparam int          FEAT_EVT_PERIODS = 3;
    localparam int          FEAT_EVT_XRUNS   = 4;
    localparam logic [31:0] FEAT_DEFINED    = 32'h0000_001F;
    localparam int          FLAG_CHMAP      = 0;
    localparam int          RATE_COUNT      = 14;
    localparam logic [63:0] RATE_DEFINED    = 64'h0000_0000_0000_3FFF;
    localparam int          FMT_COUNT       = 25;
    localparam logic [63:0] FMT_DEFINED     = 64'h0000_0000_01FF_FFFF;
    localparam logic [7:0]  DIR_OUTPUT      = 8'h00;
    localparam logic [7:0]  DIR_INPUT       = 8'h01;
    localparam logic [7:0]  CH_NONE         = 8'h00;
    localparam int          CH_MAX          = 18;
    localparam logic [7:0]  PAD_ZERO        = 8'h00;
    localparam logic [31:0] ZERO32          = 32'h0000_0000;

    typedef enum logic [2:0] {
        PSCC_IDLE,
        PSCC_PARAMS,
        PSCC_PREPARED,
        PSCC_RUNNING,
        PSCC_STOPPED,
        PSCC_RELEASED
    } pscc_state_e;

    typedef struct packed {
        logic [31:0] code;
        logic [31:0] stream_id;
        logic [31:0] buffer_bytes;
        logic [31:0] period_bytes;
        logic [31:0] features;
        logic [7:0]  channels;
        logic [7:0]  format;
        logic [7:0]  rate;
        logic [7:0]  padding;
    } pscc_req_s;

    typedef struct packed {
        logic [31:0] buffer_bytes;
        logic [31:0] period_bytes;
        logic [31:0] features;
        logic [7:0]  channels;
        logic [7:0]  format;
        logic [7:0]  rate;
    } pscc_params_s;

    // response header words and fixed config fields in transmit order
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] association;
        logic [31:0] features;
        logic [7:0]  flags;
        logic [7:0]  direction;
        logic [7:0]  channels_min;
        logic [7:0]  channels_max;
        logic [63:0] formats;
        logic [63:0] rates;
    } pscc_cfg_s;
endpackage : pscc_pkg

// >>> pscc_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module pscc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        wr_next  = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage needs no reset; it is only read while count says valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule : pscc_fifo
`default_nettype wire

// >>> pscc_ctrl.sv
// pcm stream command controller: lifecycle, parameter checks, config response
`timescale 1ns/10ps
`default_nettype none
module pscc_ctrl #(
    parameter int          STREAMS      = 4,
    parameter int          FIFO_DEPTH   = 8,
    parameter logic [31:0] INTBUF_BYTES = 32'h0001_0000,
    parameter logic [31:0] ASSOC        = 32'h0000_0000,
    parameter logic [31:0] CFG_FEATURES = 32'h0000_001C,
    parameter logic [63:0] CFG_FORMATS  = 64'h0000_0000_0000_00FF,
    parameter logic [63:0] CFG_RATES    = 64'h0000_0000_0000_00C0,
    parameter logic [7:0]  CFG_FLAGS    = 8'h01,
    parameter logic [7:0]  CFG_DIR      = 8'h00,
    parameter logic [7:0]  CFG_CH_MIN   = 8'h01,
    parameter logic [7:0]  CFG_CH_MAX   = 8'h02
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire pscc_pkg::pscc_req_s req,
    input  wire logic                req_valid,
    output logic                     req_ready,
    output pscc_pkg::pscc_cfg_s      rsp,
    output logic                     rsp_valid,
    input  wire logic                rsp_ready,
    output logic [7:0]               chmap_byte,
    output logic                     chmap_valid,
    input  wire logic                chmap_ready,
    output logic [STREAMS-1:0]       stream_running,
    output logic [STREAMS-1:0]       stream_alloc,
    output logic [STREAMS-1:0]       notify_suppress,
    output logic [STREAMS-1:0]       evt_period_en,
    output logic [STREAMS-1:0]       evt_xrun_en
);
    localparam int SW = (STREAMS > 1) ? $clog2(STREAMS) : 1;
    localparam int CW = $clog2(pscc_pkg::CH_MAX + 1);

    pscc_pkg::pscc_state_e  st_reg  [STREAMS];
    pscc_pkg::pscc_state_e  st_next [STREAMS];
    pscc_pkg::pscc_params_s par_reg [STREAMS];
    pscc_pkg::pscc_params_s par_next[STREAMS];
    pscc_pkg::pscc_cfg_s    rsp_reg, rsp_next;
    logic                   rv_reg, rv_next;
    logic                   map_pend_reg, map_pend_next;
    logic [CW-1:0]          map_idx_reg, map_idx_next;
    logic [SW-1:0]          sid;
    logic                   sid_ok, take, lc_ok, par_bad, par_unsupp, fifo_ready;
    logic [31:0]            status;
    logic [7:0]             map_val;

    // busy while a response or a channel map is still pending
    assign req_ready = !rv_reg && !map_pend_reg;
    assign take      = req_valid && req_ready;
    assign sid       = req.stream_id[SW-1:0];
    assign sid_ok    = req.stream_id < 32'(STREAMS);
    assign rsp       = rsp_reg;
    assign rsp_valid = rv_reg;

    // fixed channel positions front-left, front-right ... when map advertised; a single channel gets code 8'h02
    always_comb begin
        map_val = pscc_pkg::CH_NONE;
        if (CFG_FLAGS[pscc_pkg::FLAG_CHMAP] && (map_idx_reg < CW'(CFG_CH_MAX))) begin
            map_val = (CFG_CH_MAX == 8'h01) ? 8'h02 : 8'(map_idx_reg) + 8'h03;
        end
    end

    always_comb begin
        lc_ok = 1'b0;
        unique case (st_reg[sid])
            pscc_pkg::PSCC_IDLE,
            pscc_pkg::PSCC_PARAMS,
            pscc_pkg::PSCC_RELEASED: lc_ok = (req.code == pscc_pkg::CODE_SET_PARAMS) ||
                                             (req.code == pscc_pkg::CODE_PREPARE);
            pscc_pkg::PSCC_PREPARED: lc_ok = (req.code == pscc_pkg::CODE_SET_PARAMS) ||
                                             (req.code == pscc_pkg::CODE_PREPARE) ||
                                             (req.code == pscc_pkg::CODE_START) ||
                                             (req.code == pscc_pkg::CODE_RELEASE);
            pscc_pkg::PSCC_RUNNING:  lc_ok = (req.code == pscc_pkg::CODE_STOP);
            pscc_pkg::PSCC_STOPPED:  lc_ok = (req.code == pscc_pkg::CODE_START) ||
                                             (req.code == pscc_pkg::CODE_RELEASE);
        endcase
    end

    // malformed: broken layout or arithmetic; unsupported: valid but not offered
    always_comb begin
        par_bad = (req.period_bytes == pscc_pkg::ZERO32) ||
                  ((req.buffer_bytes % req.period_bytes) != pscc_pkg::ZERO32) ||
                  (req.padding != pscc_pkg::PAD_ZERO) ||
                  ((req.features & ~pscc_pkg::FEAT_DEFINED) != pscc_pkg::ZERO32) ||
                  (req.format >= 8'(pscc_pkg::FMT_COUNT)) ||
                  (req.rate >= 8'(pscc_pkg::RATE_COUNT)) ||
                  (req.features[pscc_pkg::FEAT_SHMEM_HOST] &&
                   req.features[pscc_pkg::FEAT_SHMEM_GUEST]);
        par_unsupp = ((req.features & ~CFG_FEATURES) != pscc_pkg::ZERO32) ||
                     req.features[pscc_pkg::FEAT_SHMEM_HOST] ||
                     req.features[pscc_pkg::FEAT_SHMEM_GUEST] ||
                     !CFG_FORMATS[req.format[5:0]] ||
                     !CFG_RATES[req.rate[5:0]] ||
                     (req.channels < CFG_CH_MIN) || (req.channels > CFG_CH_MAX) ||
                     (req.buffer_bytes > INTBUF_BYTES);
    end

    always_comb begin
        status = pscc_pkg::ST_OK;
        if (!sid_ok) begin
            status = pscc_pkg::ST_BAD_MSG;
        end else if (req.code == pscc_pkg::CODE_GET_CONFIG) begin
            status = pscc_pkg::ST_OK;
        end else if (req.code < pscc_pkg::CODE_GET_CONFIG ||
                     req.code > pscc_pkg::CODE_STOP) begin
            status = pscc_pkg::ST_NOT_SUPP;
        end else if (!lc_ok) begin
            status = pscc_pkg::ST_BAD_MSG;
        end else if (req.code == pscc_pkg::CODE_SET_PARAMS) begin
            status = par_bad ? pscc_pkg::ST_BAD_MSG :
                     (par_unsupp ? pscc_pkg::ST_NOT_SUPP : pscc_pkg::ST_OK);
        end
    end

    for (genvar i = 0; i < STREAMS; i++) begin : g_stream
        always_comb begin
            st_next[i]  = st_reg[i];
            par_next[i] = par_reg[i];
            if (take && sid_ok && (sid == SW'(i)) && (status == pscc_pkg::ST_OK)) begin
                unique case (req.code)
                    pscc_pkg::CODE_SET_PARAMS: begin
                        st_next[i]  = pscc_pkg::PSCC_PARAMS;
                        par_next[i] = '{req.buffer_bytes, req.period_bytes, req.features,
                                        req.channels, req.format, req.rate};
                    end
                    pscc_pkg::CODE_PREPARE: st_next[i] = pscc_pkg::PSCC_PREPARED;
                    pscc_pkg::CODE_START:   st_next[i] = pscc_pkg::PSCC_RUNNING;
                    pscc_pkg::CODE_STOP:    st_next[i] = pscc_pkg::PSCC_STOPPED;
                    pscc_pkg::CODE_RELEASE: st_next[i] = pscc_pkg::PSCC_RELEASED;
                    default:                st_next[i] = st_reg[i];
                endcase
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                st_reg[i]  <= pscc_pkg::PSCC_IDLE;
                par_reg[i] <= '0;
            end else begin
                st_reg[i]  <= st_next[i];
                par_reg[i] <= par_next[i];
            end
        end

        // unmuted only while running; resources held prepared through stopped
        assign stream_running[i]  = (st_reg[i] == pscc_pkg::PSCC_RUNNING);
        assign stream_alloc[i]    = (st_reg[i] == pscc_pkg::PSCC_PREPARED) ||
                                    (st_reg[i] == pscc_pkg::PSCC_RUNNING) ||
                                    (st_reg[i] == pscc_pkg::PSCC_STOPPED);
        assign notify_suppress[i] = par_reg[i].features[pscc_pkg::FEAT_POLLING];
        assign evt_period_en[i]   = par_reg[i].features[pscc_pkg::FEAT_EVT_PERIODS];
        assign evt_xrun_en[i]     = par_reg[i].features[pscc_pkg::FEAT_EVT_XRUNS];
    end

    always_comb begin
        rsp_next      = rsp_reg;
        rv_next       = rv_reg && !rsp_ready;
        map_pend_next = map_pend_reg;
        map_idx_next  = map_idx_reg;
        if (map_pend_reg && fifo_ready) begin
            map_idx_next  = map_idx_reg + 1'b1;
            map_pend_next = (map_idx_reg != CW'(pscc_pkg::CH_MAX - 1));
        end
        if (take) begin
            rv_next  = 1'b1;
            rsp_next = '0;
            rsp_next.status = status;
            if (sid_ok && (req.code == pscc_pkg::CODE_GET_CONFIG)) begin
                rsp_next.association  = ASSOC;
                rsp_next.features     = CFG_FEATURES & pscc_pkg::FEAT_DEFINED;
                rsp_next.flags        = CFG_FLAGS & 8'h01;
                rsp_next.direction    = CFG_DIR & pscc_pkg::DIR_INPUT;
                rsp_next.channels_min = CFG_CH_MIN;
                rsp_next.channels_max = CFG_CH_MAX;
                rsp_next.formats      = CFG_FORMATS & pscc_pkg::FMT_DEFINED;
                rsp_next.rates        = CFG_RATES & pscc_pkg::RATE_DEFINED;
                map_pend_next         = 1'b1;
                map_idx_next          = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_reg      <= '0;
            rv_reg       <= 1'b0;
            map_pend_reg <= 1'b0;
            map_idx_reg  <= '0;
        end else begin
            rsp_reg      <= rsp_next;
            rv_reg       <= rv_next;
            map_pend_reg <= map_pend_next;
            map_idx_reg  <= map_idx_next;
        end
    end

    // channel map bytes trail the fixed fields; stalls when the reader is slow
    pscc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_map_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (map_val),
        .in_valid  (map_pend_reg),
        .in_ready  (fifo_ready),
        .out_data  (chmap_byte),
        .out_valid (chmap_valid),
        .out_ready (chmap_ready)
    );
endmodule : pscc_ctrl
`default_nettype wire

// >>> pscc_ctrl_sva.sv
// port assertions for the pcm stream command controller
`timescale 1ns/10ps
`default_nettype none
module pscc_ctrl_sva #(
    parameter int          STREAMS      = 4,
    parameter logic [31:0] CFG_FEATURES = 32'h0000_001C
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire pscc_pkg::pscc_req_s req,
    input wire logic                req_valid,
    input wire logic                req_ready,
    input wire pscc_pkg::pscc_cfg_s rsp,
    input wire logic                rsp_valid,
    input wire logic                rsp_ready,
    input wire logic [7:0]          chmap_byte,
    input wire logic                chmap_valid,
    input wire logic                chmap_ready,
    input wire logic [STREAMS-1:0]  stream_running,
    input wire logic [STREAMS-1:0]  stream_alloc,
    input wire logic [STREAMS-1:0]  notify_suppress
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic take0;
    assign take  = req_valid && req_ready;
    assign take0 = take && req.stream_id == 32'h0000_0000;
    // accepted command on stream 0 answered with success
    sequence s_ok(logic [31:0] c);
        take0 && req.code == c ##1 rsp.status == pscc_pkg::ST_OK;
    endsequence
    a_answer_next: assert property (take |=> rsp_valid)
        else $error("no answer one cycle after take");
    a_rsp_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
        else $error("response changed before handshake");
    a_status_set: assert property (rsp_valid |-> rsp.status[31:2] == 30'h0000_2000)
        else $error("status outside the defined codes");
    a_cfg_fields: assert property (take && req.code == pscc_pkg::CODE_GET_CONFIG
        && req.stream_id < STREAMS |=> rsp.status == pscc_pkg::ST_OK
        && rsp.features == (CFG_FEATURES & pscc_pkg::FEAT_DEFINED) && rsp.direction[7:1] == 7'h00)
        else $error("config response fields wrong");
    a_bad_stream: assert property (take && req.stream_id >= STREAMS
        |=> rsp.status == pscc_pkg::ST_BAD_MSG) else $error("bad stream id not refused");
    a_start_runs: assert property (s_ok(pscc_pkg::CODE_START) |-> stream_running[0])
        else $error("start did not run stream");
    a_run_exit: assert property ($fell(stream_running[0])
        |-> $past(take0 && req.code == pscc_pkg::CODE_STOP)) else $error("running left without stop");
    a_stop_mutes: assert property (s_ok(pscc_pkg::CODE_STOP)
        |-> !stream_running[0] && stream_alloc[0]) else $error("stop state wrong");
    a_release_frees: assert property (s_ok(pscc_pkg::CODE_RELEASE) |-> !stream_alloc[0])
        else $error("release kept resources");
    a_illegal_keeps: assert property (take0 ##1 rsp.status == pscc_pkg::ST_BAD_MSG
        |-> $stable(stream_alloc) && $stable(stream_running)) else $error("refused command moved state");
    a_poll_follows: assert property (s_ok(pscc_pkg::CODE_SET_PARAMS)
        |-> notify_suppress[0] == $past(req.features[2])) else $error("polling enable wrong");
    a_map_holds: assert property (chmap_valid && !chmap_ready |=> chmap_valid && $stable(chmap_byte))
        else $error("map byte changed while stalled");
endmodule : pscc_ctrl_sva
bind pscc_ctrl pscc_ctrl_sva #(.STREAMS(STREAMS), .CFG_FEATURES(CFG_FEATURES)) pscc_ctrl_sva_inst (
    .clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rsp(rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .chmap_byte(chmap_byte),
    .chmap_valid(chmap_valid), .chmap_ready(chmap_ready), .stream_running(stream_running),
    .stream_alloc(stream_alloc), .notify_suppress(notify_suppress));
`default_nettype wire

// >>> pscc_drv_model.sv
// guest driver model: posts control requests, takes responses, drains the channel map
`timescale 1ns/10ps
`default_nettype none
module pscc_drv_model (
    input  wire logic                clk,
    input  wire logic                req_ready,
    input  wire pscc_pkg::pscc_cfg_s rsp,
    input  wire logic                rsp_valid,
    input  wire logic [7:0]          chmap_byte,
    input  wire logic                chmap_valid,
    output pscc_pkg::pscc_req_s      req,
    output logic                     req_valid,
    output logic                     rsp_ready,
    output logic                     chmap_ready
);
    bit         slow = 1'b0;
    bit         hold = 1'b0;
    bit         tick = 1'b0;
    logic [7:0] map_q[$];
    initial begin
        req         = '0;
        req_valid   = 1'b0;
        rsp_ready   = 1'b0;
        chmap_ready = 1'b0;
    end
    // slow mode stalls every other cycle, hold stalls for as long as it is set
    always @(posedge clk) begin
        tick        <= ~tick;
        chmap_ready <= !hold && (!slow || tick);
        if (chmap_valid === 1'b1 && chmap_ready)
            map_q.push_back(chmap_byte);
    end
    task automatic xfer(input pscc_pkg::pscc_req_s r, output pscc_pkg::pscc_cfg_s c, output bit ok);
        int n;
        req       <= r;
        req_valid <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 100);
        ok = req_ready === 1'b1;
        req_valid <= 1'b0;
        // released request lines show the inverse, never the stale value
        req       <= ~r;
        n = 0;
        do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 100);
        ok = ok && rsp_valid === 1'b1;
        repeat (slow ? 3 : 0) @(posedge clk);
        rsp_ready <= 1'b1;
        @(posedge clk);
        c = rsp;
        rsp_ready <= 1'b0;
    endtask : xfer
endmodule : pscc_drv_model
`default_nettype wire

// >>> tb_pscc_ctrl.sv
// self-checking testbench for the pcm stream command controller
`timescale 1ns/10ps
`default_nettype none
module tb_pscc_ctrl;
    localparam logic [31:0] BAD  = pscc_pkg::ST_BAD_MSG;
    localparam logic [31:0] NSUP = pscc_pkg::ST_NOT_SUPP;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    pscc_pkg::pscc_req_s req;
    pscc_pkg::pscc_cfg_s rsp;
    pscc_pkg::pscc_cfg_s cfg;
    logic                req_valid, req_ready, rsp_valid, rsp_ready, chmap_valid, chmap_ready;
    logic [7:0]          chmap_byte;
    logic [3:0]          stream_running, stream_alloc, notify_suppress, evt_period_en, evt_xrun_en;
    int                  n_mismatch = 0;
    int                  num_checks = 0;
    int                  n;
    // {code offset, bad status, running, allocated} per lifecycle step on stream 0
    logic [7:0]          life [19] = '{8'h44, 8'h10, 8'h44, 8'h34,
                                       8'h21, 8'h21, 8'h43,
                                       8'h17, 8'h27, 8'h51, 8'h55, 8'h15, 8'h43, 8'h51,
                                       8'h30, 8'h44, 8'h21, 8'h30, 8'h10};
    always #20 clk = ~clk;
    pscc_ctrl pscc_ctrl_inst (.clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .chmap_byte(chmap_byte), .chmap_valid(chmap_valid), .chmap_ready(chmap_ready),
        .stream_running(stream_running), .stream_alloc(stream_alloc),
        .notify_suppress(notify_suppress), .evt_period_en(evt_period_en), .evt_xrun_en(evt_xrun_en));
    pscc_drv_model pscc_drv_model_inst (.clk(clk), .req_ready(req_ready), .rsp(rsp),
        .rsp_valid(rsp_valid), .chmap_byte(chmap_byte), .chmap_valid(chmap_valid), .req(req),
        .req_valid(req_valid), .rsp_ready(rsp_ready), .chmap_ready(chmap_ready));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic pscc_pkg::pscc_req_s m(input logic [31:0] bb, pb, ft,
                                              input logic [7:0] ch, fm, rt, pd);
        m = {pscc_pkg::CODE_SET_PARAMS, 32'h2, bb, pb, ft, ch, fm, rt, pd};
    endfunction : m
    function automatic pscc_pkg::pscc_req_s sp(input logic [31:0] code, id);
        sp = m(32'h1000, 32'h400, 32'h1C, 8'h2, 8'h0, 8'h7, 8'h0);
        sp.code = code;
        sp.stream_id = id;
    endfunction : sp
    task automatic cmd(input pscc_pkg::pscc_req_s r, input logic [31:0] st);
        bit ok;
        pscc_drv_model_inst.xfer(r, cfg, ok);
        check("status", 64'(st), 64'(cfg.status));
        if (!ok) begin
            n_mismatch++;
            $display("Error handshake expected 1 seen 0");
            summarize();
        end
    endtask : cmd
    initial begin
        #2_000_000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        check("reset_out", 64'h400, 64'({req_ready, rsp_valid, chmap_valid, stream_alloc, stream_running}));
        rst_n <= 1'b1;
        @(posedge clk);
        pscc_drv_model_inst.hold <= 1'b1;
        cmd(sp(pscc_pkg::CODE_GET_CONFIG, 32'h0), pscc_pkg::ST_OK);
        check("association", 64'h0, 64'(cfg.association));
        check("features", 64'h1C, 64'(cfg.features));
        check("flags_dir", 64'h100, 64'({cfg.flags, cfg.direction}));
        check("chan_range", 64'h102, 64'({cfg.channels_min, cfg.channels_max}));
        check("formats", 64'hFF, cfg.formats);
        check("rates", 64'hC0, cfg.rates);
        repeat (20) @(posedge clk);
        // 18 map bytes exceed the 8-deep fifo, so the request side stays closed
        check("map_refused", 64'h1, 64'({req_ready, chmap_valid}));
        pscc_drv_model_inst.hold <= 1'b0;
        pscc_drv_model_inst.slow <= 1'b1;
        for (n = 0; n < 200 && pscc_drv_model_inst.map_q.size() < 18; n++) @(posedge clk);
        check("map_count", 64'h12, 64'(pscc_drv_model_inst.map_q.size()));
        @(posedge clk);
        for (int k = 0; k < 18; k++)
            check("chmap", k < 2 ? 64'(k + 3) : 64'h0, 64'(pscc_drv_model_inst.map_q[k]));
        check("map_empty", 64'h2, 64'({req_ready, chmap_valid}));
        cmd(sp(pscc_pkg::CODE_GET_CONFIG, 32'h4), BAD);
        foreach (life[i]) begin
            cmd(sp(pscc_pkg::CODE_GET_CONFIG + 32'(life[i][7:4]), 32'h0),
                life[i][2] ? BAD : pscc_pkg::ST_OK);
            check("run_alloc", 64'(life[i][1:0]), 64'({stream_running[0], stream_alloc[0]}));
        end
        pscc_drv_model_inst.slow <= 1'b0;
        cmd(sp(pscc_pkg::CODE_SET_PARAMS, 32'h2), pscc_pkg::ST_OK);
        check("events", 64'h7, 64'({notify_suppress[2], evt_period_en[2], evt_xrun_en[2]}));
        cmd(m(32'h1000, 32'h0, 32'h0, 8'h2, 8'h0, 8'h7, 8'h0), BAD);
        cmd(m(32'h300, 32'h200, 32'h0, 8'h2, 8'h0, 8'h7, 8'h0), BAD);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h2, 8'h0, 8'h7, 8'h1), BAD);
        cmd(m(32'h1000, 32'h400, 32'h20, 8'h2, 8'h0, 8'h7, 8'h0), BAD);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h2, 8'h19, 8'h7, 8'h0), BAD);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h2, 8'h0, 8'hE, 8'h0), BAD);
        cmd(m(32'h1000, 32'h400, 32'h3, 8'h2, 8'h0, 8'h7, 8'h0), BAD);
        cmd(m(32'h1000, 32'h400, 32'h1, 8'h2, 8'h0, 8'h7, 8'h0), NSUP);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h2, 8'h8, 8'h7, 8'h0), NSUP);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h2, 8'h0, 8'h0, 8'h0), NSUP);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h0, 8'h0, 8'h7, 8'h0), NSUP);
        cmd(m(32'h1000, 32'h400, 32'h0, 8'h3, 8'h0, 8'h7, 8'h0), NSUP);
        cmd(m(32'h20000, 32'h400, 32'h0, 8'h2, 8'h0, 8'h7, 8'h0), NSUP);
        check("events_kept", 64'h7, 64'({notify_suppress[2], evt_period_en[2], evt_xrun_en[2]}));
        cmd(m(32'h10000, 32'h400, 32'h0, 8'h1, 8'h7, 8'h6, 8'h0), pscc_pkg::ST_OK);
        check("events_off", 64'h0, 64'({notify_suppress[2], evt_period_en[2], evt_xrun_en[2]}));
        cmd(sp(32'h0000_0106, 32'h0), NSUP);
        cmd(sp(pscc_pkg::CODE_PREPARE, 32'h1), pscc_pkg::ST_OK);
        cmd(sp(pscc_pkg::CODE_START, 32'h1), pscc_pkg::ST_OK);
        check("running_1", 64'h2, 64'(stream_running));
        rst_n <= 1'b0;
        @(posedge clk);
        check("mid_reset", 64'h400, 64'({req_ready, rsp_valid, chmap_valid, stream_alloc, stream_running}));
        rst_n <= 1'b1;
        @(posedge clk);
        cmd(sp(pscc_pkg::CODE_START, 32'h1), BAD);
        summarize();
    end
endmodule : tb_pscc_ctrl
`default_nettype wire
